/* File: src/axstc_pkg.sv */
// Package of constants and carriers for the four-axis status and counter register bank.
// Assumes a host register port with one-cycle strobes and read data one cycle later.
// Summary of operation
// - Each axis keeps a signed 32-bit command position, loadable and readable.
// - Each axis keeps a signed 32-bit encoder position, loadable and readable.
// - One load may select several axes; all get the value, zero clears.
// - Every per-axis read names exactly one axis, X, Y, Z or U.
// - Present velocity of the chosen axis reads unsigned, pulses per second.
// - Present acceleration of the chosen axis reads unsigned, pulses per second squared.
// - Single input query returns one of ten conditions by index 0 to 9.
// - Packed status word holds the same ten conditions from bit 0 to bit 9.
// - One flag reports that some axis has a nonzero stop cause.
// - Stop cause of an axis reads zero when nothing stopped it.
// - Simultaneous stop causes add up as distinct power-of-two weights.
// - Forward software limit sets weight 1, reverse software limit weight 2.
// - Forward hardware limit sets weight 4, reverse hardware limit weight 8.
// - Servo alarm sets 16, emergency 32, weight 64 stays zero.
// - Home together with encoder index sets weight 128.
// - Software stop sets weight 256; host must clear it before resuming.
// - External drive off command disables external-signal driving on selected axes.
`default_nettype none
package axstc_pkg;
  localparam int AXSTC_NAXES = 4;
  localparam int AXSTC_AW = 8;
  // Register byte offsets
  localparam logic [7:0] AXSTC_OFS_AXSEL = 8'h00;
  localparam logic [7:0] AXSTC_OFS_CMDPOS = 8'h04;
  localparam logic [7:0] AXSTC_OFS_ENCPOS = 8'h08;
  localparam logic [7:0] AXSTC_OFS_VEL = 8'h0C;
  localparam logic [7:0] AXSTC_OFS_ACC = 8'h10;
  localparam logic [7:0] AXSTC_OFS_INWORD = 8'h14;
  localparam logic [7:0] AXSTC_OFS_INBIT = 8'h18;
  localparam logic [7:0] AXSTC_OFS_CAUSE = 8'h1C;
  localparam logic [7:0] AXSTC_OFS_ANYERR = 8'h20;
  localparam logic [7:0] AXSTC_OFS_CLEAR = 8'h24;
  localparam logic [7:0] AXSTC_OFS_SWSTOP = 8'h28;
  localparam logic [7:0] AXSTC_OFS_EXTOFF = 8'h2C;
  localparam logic [7:0] AXSTC_OFS_EXTEN = 8'h30;
  localparam logic [7:0] AXSTC_OFS_IRQST = 8'h34;
  localparam logic [7:0] AXSTC_OFS_IRQEN = 8'h38;
  localparam logic [7:0] AXSTC_OFS_IRQCLR = 8'h3C;
  // Selection register fields: read axis index, load mask and input bit index
  localparam int AXSTC_SEL_RD_LSB = 0;
  localparam int AXSTC_SEL_MASK_LSB = 4;
  localparam int AXSTC_SEL_BIT_LSB = 8;
  // Input status bit positions
  localparam int AXSTC_IN_DRIVING = 0;
  localparam int AXSTC_IN_FWDLIM = 1;
  localparam int AXSTC_IN_REVLIM = 2;
  localparam int AXSTC_IN_EMERG = 3;
  localparam int AXSTC_IN_ALARM = 4;
  localparam int AXSTC_IN_HOME = 5;
  localparam int AXSTC_IN_NEAR = 6;
  localparam int AXSTC_IN_GEN3 = 7;
  localparam int AXSTC_IN_SETTLED = 8;
  localparam int AXSTC_IN_INDEX = 9;
  localparam int AXSTC_NIN = 10;
  // Stop cause bit positions (weight = 2**position)
  localparam int AXSTC_SC_SWFWD = 0;
  localparam int AXSTC_SC_SWREV = 1;
  localparam int AXSTC_SC_HWFWD = 2;
  localparam int AXSTC_SC_HWREV = 3;
  localparam int AXSTC_SC_ALARM = 4;
  localparam int AXSTC_SC_EMERG = 5;
  localparam int AXSTC_SC_RSVD = 6;
  localparam int AXSTC_SC_HOME = 7;
  localparam int AXSTC_SC_SWSTOP = 8;
  localparam logic [31:0] AXSTC_RST_ZERO = 32'h0000_0000;
  localparam logic [3:0] AXSTC_RST_EXTEN = 4'hF;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } axstc_bus_t;
  // Per-axis live inputs from the motion core, already on sys_clk
  typedef struct packed {
    logic driving;
    logic sw_fwd;
    logic sw_rev;
    logic [31:0] velocity;
    logic [31:0] accel;
    logic enc_step;
    logic enc_dir;
    logic cmd_step;
    logic cmd_dir;
  } axstc_core_t;
  // Per-axis pins, from outside the clock domain
  typedef struct packed {
    logic fwd_lim;
    logic rev_lim;
    logic emerg;
    logic alarm;
    logic home;
    logic near_origin_sensor;
    logic general_input_three;
    logic servo_settled_input;
    logic index;
  } axstc_pins_t;
endpackage : axstc_pkg
`default_nettype wire

/* File: src/axis_status_counters.sv */
// Four-axis status, position counter and stop-cause register bank.
// Assumes count pulses and velocity/acceleration come from a motion core on sys_clk,
// and sensor pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module axstc_top
  import axstc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire axstc_bus_t bus,
  output logic [31:0] rdata,
  input wire axstc_core_t [AXSTC_NAXES-1:0] core,
  input wire axstc_pins_t [AXSTC_NAXES-1:0] pins,
  output logic [AXSTC_NAXES-1:0] stop_req,
  output logic [AXSTC_NAXES-1:0] ext_drive_en,
  output logic irq
);
  // Axis select and masks are laid out for exactly four axes
  if (AXSTC_NAXES != 4) begin : g_bad_axes
    $error("axstc_top serves exactly four axes");
  end

  typedef struct packed {
    logic [AXSTC_NAXES-1:0][31:0] cmdpos;
    logic [AXSTC_NAXES-1:0][31:0] encpos;
    logic [AXSTC_NAXES-1:0][15:0] cause;
    logic [AXSTC_NAXES-1:0][8:0] sync1;
    logic [AXSTC_NAXES-1:0][8:0] sync2;
    logic [1:0] rd_axis;
    logic [3:0] ld_mask;
    logic [3:0] bit_idx;
    logic [3:0] exten;
    logic [AXSTC_NAXES-1:0] irq_st;
    logic [AXSTC_NAXES-1:0] irq_en;
    logic [31:0] rdata;
  } axstc_state_t;

  axstc_state_t st_ff;
  axstc_state_t nxt_st;
  // Unpacked so that each generate branch owns its own element
  logic [15:0] in_word [AXSTC_NAXES];
  logic [15:0] cause_now [AXSTC_NAXES];
  logic [AXSTC_NAXES-1:0] cause_set_ev;

  // Input word and live stop conditions per axis from synchronised pins and core inputs
  genvar g;
  generate
    for (g = 0; g < AXSTC_NAXES; g++) begin : g_axis
      logic [8:0] p;
      assign p = st_ff.sync2[g];
      always_comb begin
        in_word[g] = 16'h0000;
        in_word[g][AXSTC_IN_DRIVING] = core[g].driving;
        in_word[g][AXSTC_IN_FWDLIM] = p[8];
        in_word[g][AXSTC_IN_REVLIM] = p[7];
        in_word[g][AXSTC_IN_EMERG] = p[6];
        in_word[g][AXSTC_IN_ALARM] = p[5];
        in_word[g][AXSTC_IN_HOME] = p[4];
        in_word[g][AXSTC_IN_NEAR] = p[3];
        in_word[g][AXSTC_IN_GEN3] = p[2];
        in_word[g][AXSTC_IN_SETTLED] = p[1];
        in_word[g][AXSTC_IN_INDEX] = p[0];
        cause_now[g] = 16'h0000;
        cause_now[g][AXSTC_SC_SWFWD] = core[g].sw_fwd;
        cause_now[g][AXSTC_SC_SWREV] = core[g].sw_rev;
        cause_now[g][AXSTC_SC_HWFWD] = p[8];
        cause_now[g][AXSTC_SC_HWREV] = p[7];
        cause_now[g][AXSTC_SC_ALARM] = p[5];
        cause_now[g][AXSTC_SC_EMERG] = p[6];
        cause_now[g][AXSTC_SC_HOME] = p[4] & p[0];
      end
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    cause_set_ev = '0;
    nxt_st.rdata = AXSTC_RST_ZERO;
    for (int a = 0; a < AXSTC_NAXES; a++) begin
      nxt_st.sync1[a] = {pins[a].fwd_lim, pins[a].rev_lim, pins[a].emerg, pins[a].alarm,
                         pins[a].home, pins[a].near_origin_sensor, pins[a].general_input_three,
                         pins[a].servo_settled_input, pins[a].index};
      nxt_st.sync2[a] = st_ff.sync1[a];
      // Counters follow motion pulses; a host load in the same cycle wins
      if (core[a].cmd_step) begin
        nxt_st.cmdpos[a] = core[a].cmd_dir ? st_ff.cmdpos[a] - 32'h1 : st_ff.cmdpos[a] + 32'h1;
      end
      if (core[a].enc_step) begin
        nxt_st.encpos[a] = core[a].enc_dir ? st_ff.encpos[a] - 32'h1 : st_ff.encpos[a] + 32'h1;
      end
      if (bus.wr && bus.addr == AXSTC_OFS_CMDPOS && st_ff.ld_mask[a]) begin
        nxt_st.cmdpos[a] = bus.wdata;
      end
      if (bus.wr && bus.addr == AXSTC_OFS_ENCPOS && st_ff.ld_mask[a]) begin
        nxt_st.encpos[a] = bus.wdata;
      end
      // Clear first, then set, so a cause arriving during the clear survives
      if (bus.wr && bus.addr == AXSTC_OFS_CLEAR && bus.wdata[a]) begin
        nxt_st.cause[a] = 16'h0000;
      end
      if (bus.wr && bus.addr == AXSTC_OFS_SWSTOP && bus.wdata[a]) begin
        nxt_st.cause[a][AXSTC_SC_SWSTOP] = 1'b1;
      end
      nxt_st.cause[a] = nxt_st.cause[a] | cause_now[a];
      nxt_st.cause[a][AXSTC_SC_RSVD] = 1'h0;
      cause_set_ev[a] = |(nxt_st.cause[a] & ~st_ff.cause[a]);
      if (bus.wr && bus.addr == AXSTC_OFS_IRQCLR && bus.wdata[a]) begin
        nxt_st.irq_st[a] = 1'b0;
      end
      if (cause_set_ev[a]) begin
        nxt_st.irq_st[a] = 1'b1;
      end
      if (bus.wr && bus.addr == AXSTC_OFS_EXTOFF && bus.wdata[a]) begin
        nxt_st.exten[a] = 1'b0;
      end
    end
    if (bus.wr) begin
      unique case (bus.addr)
        AXSTC_OFS_AXSEL: begin
          nxt_st.rd_axis = bus.wdata[AXSTC_SEL_RD_LSB +: 2];
          nxt_st.ld_mask = bus.wdata[AXSTC_SEL_MASK_LSB +: 4];
          nxt_st.bit_idx = bus.wdata[AXSTC_SEL_BIT_LSB +: 4];
        end
        AXSTC_OFS_EXTEN: nxt_st.exten = bus.wdata[3:0];
        AXSTC_OFS_IRQEN: nxt_st.irq_en = bus.wdata[3:0];
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        AXSTC_OFS_AXSEL: begin
          nxt_st.rdata = {20'h00000, st_ff.bit_idx, st_ff.ld_mask, 2'h0, st_ff.rd_axis};
        end
        AXSTC_OFS_CMDPOS: nxt_st.rdata = st_ff.cmdpos[st_ff.rd_axis];
        AXSTC_OFS_ENCPOS: nxt_st.rdata = st_ff.encpos[st_ff.rd_axis];
        AXSTC_OFS_VEL: nxt_st.rdata = core[st_ff.rd_axis].velocity;
        AXSTC_OFS_ACC: nxt_st.rdata = core[st_ff.rd_axis].accel;
        AXSTC_OFS_INWORD: nxt_st.rdata = {16'h0000, in_word[st_ff.rd_axis]};
        AXSTC_OFS_INBIT: begin
          // Indexes above 9 read off
          if (st_ff.bit_idx < 4'(AXSTC_NIN)) begin
            nxt_st.rdata = {31'h0, in_word[st_ff.rd_axis][st_ff.bit_idx]};
          end
        end
        AXSTC_OFS_CAUSE: nxt_st.rdata = {16'h0000, st_ff.cause[st_ff.rd_axis]};
        AXSTC_OFS_ANYERR: begin
          nxt_st.rdata = {31'h0, |{st_ff.cause[0], st_ff.cause[1],
                                   st_ff.cause[2], st_ff.cause[3]}};
        end
        AXSTC_OFS_EXTEN: nxt_st.rdata = {28'h0, st_ff.exten};
        AXSTC_OFS_IRQST: nxt_st.rdata = {28'h0, st_ff.irq_st};
        AXSTC_OFS_IRQEN: nxt_st.rdata = {28'h0, st_ff.irq_en};
        default: nxt_st.rdata = AXSTC_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.exten <= AXSTC_RST_EXTEN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  // Motion core must hold the axis stopped while a software stop is latched
  always_comb begin
    for (int a = 0; a < AXSTC_NAXES; a++) begin
      stop_req[a] = st_ff.cause[a][AXSTC_SC_SWSTOP];
    end
  end
  assign ext_drive_en = st_ff.exten;
  assign irq = |(st_ff.irq_st & st_ff.irq_en);
endmodule // axstc_top
`default_nettype wire

/* File: sim/axstc_monitor.sv */
// Port checker for the status bank.
// Assumes a bind onto axstc_top.
`timescale 1ns/1ns
`default_nettype none
module axstc_monitor
  import axstc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire axstc_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic [3:0] stop_req,
  input wire logic [3:0] ext_drive_en,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Axis Z write with its bit set
  sequence s_wr(logic [7:0] a);
    bus.wr && bus.addr == a && bus.wdata[2];
  endsequence
  a_read_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0) else $error("rdata");
  a_unmapped_rd: assert property (bus.rd && bus.addr == 8'h40 |=> rdata == 32'h0)
    else $error("unmapped");
  a_stop_set: assert property (s_wr(AXSTC_OFS_SWSTOP) |=> stop_req[2]) else $error("set");
  a_stop_clear: assert property (s_wr(AXSTC_OFS_CLEAR) |=> !stop_req[2]) else $error("clr");
  a_stop_held: assert property (stop_req[2] && !(bus.wr && bus.addr == AXSTC_OFS_CLEAR)
    |=> stop_req[2]) else $error("held");
  a_stop_quiet: assert property (!bus.wr |=> $stable(stop_req)) else $error("stop");
  a_ext_off: assert property (s_wr(AXSTC_OFS_EXTOFF) |=> !ext_drive_en[2]) else $error("off");
  a_ext_quiet: assert property (!bus.wr |=> $stable(ext_drive_en)) else $error("ext");
endmodule // axstc_monitor
`default_nettype wire

/* File: sim/axstc_host.sv */
// Host model on the register port.
// Assumes the bench calls its tasks hierarchically.
`timescale 1ns/1ns
`default_nettype none
module axstc_host
  import axstc_pkg::*;
(
  input wire logic sys_clk,
  output var axstc_bus_t bus,
  input wire logic [31:0] rdata
);
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
    // Let the write edge land before the bench looks
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
endmodule // axstc_host
`default_nettype wire

/* File: sim/axis_status_counters_tb.sv */
// Bench for the status bank.
// Assumes axstc_host on the bus; core and pins driven here.
`timescale 1ns/1ns
`default_nettype none
module axis_status_counters_tb;
  import axstc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  axstc_bus_t bus;
  logic [31:0] rdata;
  axstc_core_t [3:0] core = '0;
  axstc_pins_t [3:0] pins = '0;
  logic [3:0] stop_req;
  logic [3:0] ext_drive_en;
  logic irq;
  int n_fail = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  axstc_top uut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .core(core),
    .pins(pins), .stop_req(stop_req), .ext_drive_en(ext_drive_en), .irq(irq));
  axstc_host host (.sys_clk(sys_clk), .bus(bus), .rdata(rdata));
  task automatic finish_test;
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk(nm, exp, d);
  endtask
  task automatic t_counters;
    for (int a = 0; a < 4; a++) core[a].velocity <= 32'hF000_0000 + 32'(a);
    for (int a = 0; a < 4; a++) core[a].accel <= 32'h8000_0100 + 32'(a);
    host.wr(AXSTC_OFS_AXSEL, 32'h0000_00F0);
    host.wr(AXSTC_OFS_CMDPOS, 32'h8000_0000);
    host.wr(AXSTC_OFS_ENCPOS, 32'h7FFF_FFFF);
    host.wr(AXSTC_OFS_AXSEL, 32'h0000_0050);
    host.wr(AXSTC_OFS_CMDPOS, 32'h0);
    host.wr(AXSTC_OFS_VEL, 32'h0);
    for (int a = 0; a < 4; a++) begin
      host.wr(AXSTC_OFS_AXSEL, 32'(a));
      rchk("cmdpos", AXSTC_OFS_CMDPOS, a[0] ? 32'h8000_0000 : 32'h0);
      rchk("encpos", AXSTC_OFS_ENCPOS, 32'h7FFF_FFFF);
      rchk("vel", AXSTC_OFS_VEL, 32'hF000_0000 + 32'(a));
      rchk("acc", AXSTC_OFS_ACC, 32'h8000_0100 + 32'(a));
    end
    // One count pulse on axis U: command up, encoder down
    core[3].cmd_step <= 1'b1;
    core[3].enc_step <= 1'b1;
    core[3].enc_dir <= 1'b1;
    @(posedge sys_clk);
    core[3].cmd_step <= 1'b0;
    core[3].enc_step <= 1'b0;
    host.wr(AXSTC_OFS_AXSEL, 32'h3);
    rchk("cmdstep", AXSTC_OFS_CMDPOS, 32'h8000_0001);
    rchk("encstep", AXSTC_OFS_ENCPOS, 32'h7FFF_FFFE);
  endtask
  task automatic t_inputs;
    logic [9:0] v;
    for (int i = 0; i < 10; i++) begin
      v = 10'h1 << i;
      core[1].driving <= v[0];
      pins[1] <= {v[1], v[2], v[3], v[4], v[5], v[6], v[7], v[8], v[9]};
      host.wr(AXSTC_OFS_AXSEL, 32'h1 | (32'(i) << 8));
      rchk("inword", AXSTC_OFS_INWORD, {22'h0, v});
      rchk("inbit", AXSTC_OFS_INBIT, 32'h1);
      host.wr(AXSTC_OFS_AXSEL, 32'h1 | (32'((i + 1) % 10) << 8));
      rchk("inbit off", AXSTC_OFS_INBIT, 32'h0);
    end
    host.wr(AXSTC_OFS_AXSEL, 32'h0000_0A01);
    rchk("inbit", AXSTC_OFS_INBIT, 32'h0);
    pins[1] <= '0;
  endtask
  task automatic drive(input int k, input logic v);
    case (k)
      0: core[2].sw_fwd <= v;
      1: core[2].sw_rev <= v;
      2: pins[2].fwd_lim <= v;
      3: pins[2].rev_lim <= v;
      4: pins[2].alarm <= v;
      5: pins[2].emerg <= v;
      default: pins[2].home <= v;
    endcase
  endtask
  task automatic t_causes;
    int w[8] = '{0, 1, 2, 3, 4, 5, 7, 8};
    host.wr(AXSTC_OFS_CLEAR, 32'hF);
    host.wr(AXSTC_OFS_AXSEL, 32'h2);
    rchk("anyerr", AXSTC_OFS_ANYERR, 32'h0);
    foreach (w[j]) begin
      if (w[j] == 8) host.wr(AXSTC_OFS_SWSTOP, 32'h4);
      else drive(w[j], 1'b1);
      pins[2].index <= (w[j] == 7);
      repeat (3) @(posedge sys_clk);
      drive(w[j], 1'b0);
      pins[2].index <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rchk("cause", AXSTC_OFS_CAUSE, 32'h1 << w[j]);
      rchk("anyerr", AXSTC_OFS_ANYERR, 32'h1);
      host.wr(AXSTC_OFS_CLEAR, 32'h4);
      rchk("cleared", AXSTC_OFS_CAUSE, 32'h0);
    end
    // Home without index must add nothing
    for (int k = 4; k < 7; k++) drive(k, 1'b1);
    repeat (4) @(posedge sys_clk);
    host.wr(AXSTC_OFS_CLEAR, 32'h4);
    rchk("sum", AXSTC_OFS_CAUSE, 32'h30);
    for (int k = 4; k < 7; k++) drive(k, 1'b0);
  endtask
  task automatic t_ext_irq;
    host.wr(AXSTC_OFS_EXTOFF, 32'h5);
    rchk("exten", AXSTC_OFS_EXTEN, 32'hA);
    chk("ext_drive_en", 32'hA, {28'h0, ext_drive_en});
    host.wr(AXSTC_OFS_CLEAR, 32'hF);
    host.wr(AXSTC_OFS_IRQCLR, 32'hF);
    host.wr(AXSTC_OFS_IRQEN, 32'h4);
    chk("irq idle", 32'h0, {31'h0, irq});
    host.wr(AXSTC_OFS_SWSTOP, 32'h4);
    chk("stop_req", 32'h4, {28'h0, stop_req});
    rchk("irqst", AXSTC_OFS_IRQST, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    host.wr(AXSTC_OFS_IRQEN, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    host.wr(AXSTC_OFS_IRQEN, 32'h4);
    host.wr(AXSTC_OFS_CLEAR, 32'h4);
    host.wr(AXSTC_OFS_IRQCLR, 32'h4);
    chk("irq clr", 32'h0, {27'h0, irq, stop_req});
  endtask
  // Reset in mid-run must restore every register, not only the idle ones
  task automatic t_reset;
    host.wr(AXSTC_OFS_AXSEL, 32'h0000_00F0);
    host.wr(AXSTC_OFS_CMDPOS, 32'h1234_5678);
    host.wr(AXSTC_OFS_SWSTOP, 32'hF);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("rerun reset", 32'hF, {23'h0, irq, stop_req, ext_drive_en});
    rchk("reset cmdpos", AXSTC_OFS_CMDPOS, 32'h0);
    rchk("reset anyerr", AXSTC_OFS_ANYERR, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("reset", 32'hF, {23'h0, irq, stop_req, ext_drive_en});
    rchk("cause", AXSTC_OFS_CAUSE, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    t_counters;
    t_inputs;
    t_causes;
    t_ext_irq;
    t_reset;
    finish_test;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    finish_test;
  end
endmodule // axis_status_counters_tb
bind axstc_top axstc_monitor mon (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
  .stop_req(stop_req), .ext_drive_en(ext_drive_en), .irq(irq));
`default_nettype wire
